//--- hw/sosi_map.svh
// register map, field layout, reset values and timing constants of the
// safety output start-up interlock; included by the design files and by the bench
`ifndef SOSI_MAP_SVH
`define SOSI_MAP_SVH

`define ADDR_W 8
`define ADDR_CTRL 8'h00
`define ADDR_CFG 8'h04
`define ADDR_RESP 8'h08
`define ADDR_ROUTE 8'h0C
`define ADDR_STATUS 8'h10
`define ADDR_IRQ_STAT 8'h14
`define ADDR_IRQ_MASK 8'h18

`define CTRL_RST 32'h0000_0004
`define CFG_RST 32'h0000_0000
`define RESP_RST 32'h0000_0064
`define ROUTE_RST 32'h0000_0039
`define MASK_RST 32'h0000_0000

`define CTRL_WMASK 32'h0000_003F
`define CFG_WMASK 32'h0000_FF07
`define RESP_WMASK 32'h0000_FFFF
`define ROUTE_WMASK 32'h0000_003F
`define MASK_WMASK 32'h0000_0007

`define CTRL_FOUR_BIT 0
`define CTRL_START_LSB 1
`define CTRL_PAIR_LSB 3
`define CFG_RES_LSB 0
`define CFG_SPEED_LSB 8
`define ROUTE_MSG_LSB 0
`define ROUTE_AUX_LSB 2
`define ROUTE_CIO_LSB 4

`define IRQ_W 3
`define IRQ_OFF 0
`define IRQ_ACCEPT 1
`define IRQ_REJECT 2

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define RES_CODE_MAX 3'h5
`define RES_MM_0 8'h1E
`define RES_MM_1 8'h28
`define RES_MM_2 8'h32
`define RES_MM_3 8'h3C
`define RES_MM_4 8'h46
`define RES_MM_5 8'h96

`define CLK_MHZ 10
`define HOLD_MIN_US 120000
`define HOLD_MAX_US 4000000
`define HOLD_MIN_CYC (`HOLD_MIN_US * `CLK_MHZ)
`define HOLD_MAX_CYC (`HOLD_MAX_US * `CLK_MHZ)

`endif

//--- hw/sosi_pkg.sv
// types shared by the start-up interlock design files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package sosi_pkg;

  typedef enum logic [1:0] {
    auto_start_restart = 2'b00,
    start_interlock_auto = 2'b01,
    start_restart_interlock_mode = 2'b10
  } startup_e;

  typedef enum logic [1:0] {
    st_locked = 2'b00,
    st_run = 2'b01,
    st_off_viol = 2'b10
  } run_state_e;

  typedef enum logic [1:0] {
    sel_zero = 2'b00,
    sel_b_clear = 2'b01,
    sel_warn_a = 2'b10,
    sel_warn_b = 2'b11
  } route_sel_e;

endpackage : sosi_pkg

`default_nettype wire

//--- hw/press_timer.sv
// reset button hold-time qualifier: judges each press on its release
// assumes button_in is already synchronised to clk_in
`include "sosi_map.svh"
`default_nettype none

module press_timer #(
  parameter int unsigned MIN_CYC = `HOLD_MIN_CYC,
  parameter int unsigned MAX_CYC = `HOLD_MAX_CYC,
  parameter int unsigned W = $clog2(MAX_CYC + 2)
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic button_in,
  output logic press_ok_out,
  output logic press_bad_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic prev;
    logic ok;
    logic bad;
  } timer_s;

  timer_s cur_ff;
  timer_s nxt_ff;

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.prev = button_in;
    nxt_ff.ok = 1'b0;
    nxt_ff.bad = 1'b0;
    if (button_in) begin
      // saturates one past the maximum so overlong presses stay overlong
      if (cur_ff.cnt <= W'(MAX_CYC)) begin
        nxt_ff.cnt = W'(cur_ff.cnt + W'(1));
      end
    end else begin
      if (cur_ff.prev) begin
        if (cur_ff.cnt >= W'(MIN_CYC) && cur_ff.cnt <= W'(MAX_CYC)) begin
          nxt_ff.ok = 1'b1;
        end else begin
          nxt_ff.bad = 1'b1;
        end
      end
      nxt_ff.cnt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign press_ok_out = cur_ff.ok;
  assign press_bad_out = cur_ff.bad;

  press_window_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (cur_ff.prev && !button_in && cur_ff.cnt >= W'(MIN_CYC) && cur_ff.cnt <= W'(MAX_CYC))
    |=> (press_ok_out && !press_bad_out))
    else $error("press inside hold window not accepted");

  press_ignored_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (cur_ff.prev && !button_in && (cur_ff.cnt < W'(MIN_CYC) || cur_ff.cnt > W'(MAX_CYC)))
    |=> (!press_ok_out && press_bad_out))
    else $error("press outside hold window not rejected");

endmodule : press_timer

`default_nettype wire

//--- hw/safety_output_startup_interlock.sv
// safety output start-up interlock: field violations to safety output pair
// and indication outputs, start-up modes, axi4-lite register slave
// assumes violation pins and button are asynchronous, one clock domain
// Function
// - single mode: pair A from one field pair
// - four field mode: two protective, two warning fields
// - one index selects both A and B pairs
// - protective A violation turns pair A off
// - protective B only drives B clear indication
// - warning A/B signals routed by configurable assignment
// - bank resolution: 30,40,50,60,70,150 mm
// - bank maximum vehicle speed setting
// - outputs off a fixed 3 edges after the pin; response time only reported
// - one start-up behaviour per bank, three choices
// - automatic mode: start and restart unaided
// - start interlock, then automatic restart
// - restart interlock holds off until reset
// - restart interlock always includes start interlock
// - start interlock released only by reset button
// - valid reset press held 0.12 s to 4 s
`include "sosi_map.svh"
`default_nettype none

module safety_output_startup_interlock #(
  parameter int unsigned PAIRS = 8,
  parameter int unsigned HOLD_MIN_CYC = `HOLD_MIN_CYC,
  parameter int unsigned HOLD_MAX_CYC = `HOLD_MAX_CYC
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [`ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [PAIRS-1:0] prot_a_viol_in,
  input wire logic [PAIRS-1:0] warn_a_viol_in,
  input wire logic [PAIRS-1:0] prot_b_viol_in,
  input wire logic [PAIRS-1:0] warn_b_viol_in,
  input wire logic supply_ok_in,
  input wire logic reset_button_in,
  output logic [1:0] safety_output_pair_a_out,
  output logic non_safe_message_output_out,
  output logic aux_output_one_out,
  output logic config_io_one_out,
  output logic [7:0] resolution_mm_out,
  output logic [7:0] vehicle_speed_out,
  output logic [15:0] response_time_out,
  output logic irq_out
);

  localparam int unsigned SW = 4 * PAIRS + 2;
  localparam int unsigned IW = (PAIRS > 1) ? $clog2(PAIRS) : 1;

  typedef struct packed {
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    sosi_pkg::run_state_e state;
    logic [31:0] ctrl;
    logic [31:0] cfg;
    logic [31:0] resp;
    logic [31:0] route;
    logic [31:0] mask;
    logic [`IRQ_W-1:0] irq_stat;
    logic aw_held;
    logic [`ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] safety;
    logic msg;
    logic aux;
    logic cio;
    logic [7:0] res_mm;
    logic irq;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  logic press_ok;
  logic press_bad;
  logic four_field;
  logic [IW-1:0] pair_idx;
  logic pa;
  logic wa;
  logic pb;
  logic wb;
  logic b_clear;
  logic supply;
  logic free;
  sosi_pkg::startup_e mode;
  logic [`IRQ_W-1:0] irq_ev;
  logic [`IRQ_W-1:0] irq_clr;
  logic [31:0] wr_val;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_val[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  function automatic logic route_pick(input logic [1:0] sel, input logic bcl,
                                      input logic wav, input logic wbv);
    logic val;
    val = 1'b0;
    unique case (sosi_pkg::route_sel_e'(sel))
      sosi_pkg::sel_zero: val = 1'b0;
      sosi_pkg::sel_b_clear: val = bcl;
      sosi_pkg::sel_warn_a: val = wav;
      sosi_pkg::sel_warn_b: val = wbv;
    endcase
    return val;
  endfunction : route_pick

  function automatic logic [7:0] res_to_mm(input logic [2:0] code);
    logic [7:0] mm;
    mm = `RES_MM_5;
    case (code)
      3'h0: mm = `RES_MM_0;
      3'h1: mm = `RES_MM_1;
      3'h2: mm = `RES_MM_2;
      3'h3: mm = `RES_MM_3;
      3'h4: mm = `RES_MM_4;
      default: mm = `RES_MM_5;
    endcase
    return mm;
  endfunction : res_to_mm

  press_timer #(
    .MIN_CYC(HOLD_MIN_CYC),
    .MAX_CYC(HOLD_MAX_CYC)
  ) u_press (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .button_in(cur_ff.sync2[SW-1]),
    .press_ok_out(press_ok),
    .press_bad_out(press_bad)
  );

  always_comb begin
    nxt_ff = cur_ff;
    irq_ev = '0;
    irq_clr = '0;
    wr_val = '0;
    nxt_ff.sync1 = {reset_button_in, supply_ok_in, warn_b_viol_in, prot_b_viol_in,
                    warn_a_viol_in, prot_a_viol_in};
    nxt_ff.sync2 = cur_ff.sync1;

    four_field = cur_ff.ctrl[`CTRL_FOUR_BIT];
    pair_idx = cur_ff.ctrl[`CTRL_PAIR_LSB +: IW];
    // one index picks the A and the B pair together
    pa = cur_ff.sync2[pair_idx];
    wa = cur_ff.sync2[PAIRS + pair_idx];
    // single mode evaluates pair A alone; B inputs are masked off
    pb = four_field & cur_ff.sync2[2*PAIRS + pair_idx];
    wb = four_field & cur_ff.sync2[3*PAIRS + pair_idx];
    b_clear = !pb;
    supply = cur_ff.sync2[SW-2];
    free = supply && !pa;
    // code 3 is undefined: fall back to the strictest behaviour
    if (cur_ff.ctrl[`CTRL_START_LSB +: 2] == 2'b11) begin
      mode = sosi_pkg::start_restart_interlock_mode;
    end else begin
      mode = sosi_pkg::startup_e'(cur_ff.ctrl[`CTRL_START_LSB +: 2]);
    end

    unique case (cur_ff.state)
      sosi_pkg::st_locked: begin
        // power-up and supply loss always land here
        if (free && mode == sosi_pkg::auto_start_restart) begin
          nxt_ff.state = sosi_pkg::st_run;
        end else if (free && press_ok) begin
          nxt_ff.state = sosi_pkg::st_run;
        end
      end
      sosi_pkg::st_run: begin
        if (!supply) begin
          nxt_ff.state = sosi_pkg::st_locked;
        end else if (pa) begin
          if (mode == sosi_pkg::start_restart_interlock_mode) begin
            // the restart lock reuses the start lock state
            nxt_ff.state = sosi_pkg::st_locked;
          end else begin
            nxt_ff.state = sosi_pkg::st_off_viol;
          end
        end
      end
      sosi_pkg::st_off_viol: begin
        if (!supply || mode == sosi_pkg::start_restart_interlock_mode) begin
          nxt_ff.state = sosi_pkg::st_locked;
        end else if (!pa) begin
          nxt_ff.state = sosi_pkg::st_run;
        end
      end
      default: nxt_ff.state = sosi_pkg::st_locked;
    endcase

    // off follows the violation by the sync stages plus one edge
    nxt_ff.safety = {2{nxt_ff.state == sosi_pkg::st_run}};
    nxt_ff.msg = route_pick(cur_ff.route[`ROUTE_MSG_LSB +: 2], b_clear, wa, wb);
    nxt_ff.aux = route_pick(cur_ff.route[`ROUTE_AUX_LSB +: 2], b_clear, wa, wb);
    nxt_ff.cio = route_pick(cur_ff.route[`ROUTE_CIO_LSB +: 2], b_clear, wa, wb);

    irq_ev[`IRQ_OFF] = cur_ff.state == sosi_pkg::st_run && nxt_ff.state != sosi_pkg::st_run;
    irq_ev[`IRQ_ACCEPT] = press_ok && cur_ff.state == sosi_pkg::st_locked &&
                          nxt_ff.state == sosi_pkg::st_run;
    // a press during a violation counts as rejected
    irq_ev[`IRQ_REJECT] = press_bad || (press_ok && !irq_ev[`IRQ_ACCEPT]);

    if (s_axi_awvalid_in && cur_ff.awready) begin
      nxt_ff.aw_held = 1'b1;
      nxt_ff.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && cur_ff.wready) begin
      nxt_ff.w_held = 1'b1;
      nxt_ff.wdata = s_axi_wdata_in;
      nxt_ff.wstrb = s_axi_wstrb_in;
    end
    if (cur_ff.bvalid && s_axi_bready_in) begin
      nxt_ff.bvalid = 1'b0;
    end
    if (cur_ff.aw_held && cur_ff.w_held && !cur_ff.bvalid) begin
      nxt_ff.aw_held = 1'b0;
      nxt_ff.w_held = 1'b0;
      nxt_ff.bvalid = 1'b1;
      nxt_ff.bresp = `RESP_OKAY;
      case (cur_ff.awaddr)
        `ADDR_CTRL: begin
          nxt_ff.ctrl = merge_bytes(cur_ff.ctrl, cur_ff.wdata, cur_ff.wstrb) & `CTRL_WMASK;
        end
        `ADDR_CFG: begin
          wr_val = merge_bytes(cur_ff.cfg, cur_ff.wdata, cur_ff.wstrb) & `CFG_WMASK;
          // undefined resolution codes keep the previous resolution
          if (wr_val[`CFG_RES_LSB +: 3] > `RES_CODE_MAX) begin
            wr_val[`CFG_RES_LSB +: 3] = cur_ff.cfg[`CFG_RES_LSB +: 3];
          end
          nxt_ff.cfg = wr_val;
        end
        `ADDR_RESP: begin
          nxt_ff.resp = merge_bytes(cur_ff.resp, cur_ff.wdata, cur_ff.wstrb) & `RESP_WMASK;
        end
        `ADDR_ROUTE: begin
          nxt_ff.route = merge_bytes(cur_ff.route, cur_ff.wdata, cur_ff.wstrb) & `ROUTE_WMASK;
        end
        `ADDR_IRQ_MASK: begin
          nxt_ff.mask = merge_bytes(cur_ff.mask, cur_ff.wdata, cur_ff.wstrb) & `MASK_WMASK;
        end
        `ADDR_STATUS, `ADDR_IRQ_STAT: nxt_ff.bresp = `RESP_OKAY;
        default: nxt_ff.bresp = `RESP_SLVERR;
      endcase
    end
    nxt_ff.awready = !nxt_ff.aw_held;
    nxt_ff.wready = !nxt_ff.w_held;

    if (cur_ff.rvalid && s_axi_rready_in) begin
      nxt_ff.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && cur_ff.arready) begin
      nxt_ff.rvalid = 1'b1;
      nxt_ff.rresp = `RESP_OKAY;
      case (s_axi_araddr_in)
        `ADDR_CTRL: nxt_ff.rdata = cur_ff.ctrl;
        `ADDR_CFG: nxt_ff.rdata = cur_ff.cfg;
        `ADDR_RESP: nxt_ff.rdata = cur_ff.resp;
        `ADDR_ROUTE: nxt_ff.rdata = cur_ff.route;
        `ADDR_STATUS: begin
          nxt_ff.rdata = {24'h00_0000, supply, wb, wa, pb, pa, cur_ff.state,
                          cur_ff.safety[0]};
        end
        `ADDR_IRQ_STAT: begin
          nxt_ff.rdata = {{(32-`IRQ_W){1'b0}}, cur_ff.irq_stat};
          irq_clr = '1;
        end
        `ADDR_IRQ_MASK: nxt_ff.rdata = cur_ff.mask;
        default: begin
          nxt_ff.rdata = 32'h0000_0000;
          nxt_ff.rresp = `RESP_SLVERR;
        end
      endcase
    end
    nxt_ff.arready = !nxt_ff.rvalid;

    // an event in the clearing read's cycle survives the clear
    nxt_ff.irq_stat = (cur_ff.irq_stat & ~irq_clr) | irq_ev;
    nxt_ff.irq = |(nxt_ff.irq_stat & nxt_ff.mask[`IRQ_W-1:0]);
    nxt_ff.res_mm = res_to_mm(nxt_ff.cfg[`CFG_RES_LSB +: 3]);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cur_ff <= '0;
      cur_ff.ctrl <= `CTRL_RST;
      cur_ff.cfg <= `CFG_RST;
      cur_ff.resp <= `RESP_RST;
      cur_ff.route <= `ROUTE_RST;
      cur_ff.mask <= `MASK_RST;
      cur_ff.res_mm <= `RES_MM_0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign s_axi_awready_out = cur_ff.awready;
  assign s_axi_wready_out = cur_ff.wready;
  assign s_axi_bvalid_out = cur_ff.bvalid;
  assign s_axi_bresp_out = cur_ff.bresp;
  assign s_axi_arready_out = cur_ff.arready;
  assign s_axi_rvalid_out = cur_ff.rvalid;
  assign s_axi_rdata_out = cur_ff.rdata;
  assign s_axi_rresp_out = cur_ff.rresp;
  assign safety_output_pair_a_out = cur_ff.safety;
  assign non_safe_message_output_out = cur_ff.msg;
  assign aux_output_one_out = cur_ff.aux;
  assign config_io_one_out = cur_ff.cio;
  assign resolution_mm_out = cur_ff.res_mm;
  assign vehicle_speed_out = cur_ff.cfg[`CFG_SPEED_LSB +: 8];
  assign response_time_out = cur_ff.resp[15:0];
  assign irq_out = cur_ff.irq;

  viol_a_off_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    pa |=> (safety_output_pair_a_out == 2'b00))
    else $error("pair A not off after protective A violation");

  off_in_time_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    $rose(cur_ff.sync2[pair_idx]) && $stable(pair_idx) |=> !safety_output_pair_a_out[0])
    else $error("pair A switched off late");

  b_isolated_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (cur_ff.state == sosi_pkg::st_run && !pa && supply) |=> (cur_ff.state == sosi_pkg::st_run))
    else $error("run state left without A violation or supply loss");

  restart_relock_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (mode == sosi_pkg::start_restart_interlock_mode && cur_ff.state == sosi_pkg::st_run && pa)
    |=> (cur_ff.state == sosi_pkg::st_locked && safety_output_pair_a_out == 2'b00))
    else $error("restart interlock not engaged");

  auto_restart_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (mode == sosi_pkg::start_interlock_auto && cur_ff.state == sosi_pkg::st_off_viol &&
     !pa && supply) |=> (cur_ff.state == sosi_pkg::st_run))
    else $error("automatic restart missed");

  start_locked_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (mode != sosi_pkg::auto_start_restart && cur_ff.state == sosi_pkg::st_locked && !press_ok)
    |=> (cur_ff.state != sosi_pkg::st_run))
    else $error("start interlock released without reset press");

  reset_in_viol_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (press_ok && pa) |=> !safety_output_pair_a_out[0])
    else $error("reset accepted during violation");

  auto_start_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (mode == sosi_pkg::auto_start_restart && cur_ff.state == sosi_pkg::st_locked && free)
    |=> (cur_ff.state == sosi_pkg::st_run && safety_output_pair_a_out == 2'b11))
    else $error("automatic start missed");

  single_mode_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (!four_field && cur_ff.route[`ROUTE_AUX_LSB +: 2] == 2'b11) |=> !aux_output_one_out)
    else $error("B warning passed in single mode");

  irq_level_a: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    irq_out == |(cur_ff.irq_stat & cur_ff.mask[`IRQ_W-1:0]))
    else $error("interrupt level disagrees with status and mask");

endmodule : safety_output_startup_interlock

`default_nettype wire

//--- dv/reset_operator.sv
// operator reset button model for the start-up interlock bench
// assumes the caller enters press right after a rising clk_in edge
`default_nettype none

module reset_operator (
  input wire logic clk_in,
  output logic button_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial button_out = 1'b0;

  // hold for n cycles, then stay released long enough for the judgement to land
  task automatic press(input int n);
    @(posedge clk_in);
    button_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    button_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask : press
endmodule : reset_operator

`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the safety output start-up interlock
// assumes small hold limits (12..40 cycles) and the pin latency of 3 edges
`include "sosi_map.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
  } row_s;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'b1;
  logic rready = 1'b1;
  int stall = 0;
  logic [7:0] prot_a = 8'h00;
  logic [7:0] warn_a = 8'h00;
  logic [7:0] prot_b = 8'h00;
  logic [7:0] warn_b = 8'h00;
  logic supply = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, button, msg, aux, cio, irq;
  logic [1:0] bresp, rresp, pair, br;
  logic [31:0] rdata;
  logic [7:0] res_mm, speed;
  logic [15:0] resp_t;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] mm [6] = '{8'h1E, 8'h28, 8'h32, 8'h3C, 8'h46, 8'h96};
  row_s rows [6] = '{'{`ADDR_CTRL, 32'h04, `RESP_OKAY}, '{`ADDR_CFG, 32'h0, `RESP_OKAY},
    '{`ADDR_RESP, 32'h64, `RESP_OKAY}, '{`ADDR_ROUTE, 32'h39, `RESP_OKAY},
    '{`ADDR_IRQ_MASK, 32'h0, `RESP_OKAY}, '{8'h1C, 32'h0, `RESP_SLVERR}};

  safety_output_startup_interlock #(.HOLD_MIN_CYC(12), .HOLD_MAX_CYC(40)) uut (
    .clk_in(clk), .sys_rst_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .prot_a_viol_in(prot_a), .warn_a_viol_in(warn_a), .prot_b_viol_in(prot_b),
    .warn_b_viol_in(warn_b), .supply_ok_in(supply), .reset_button_in(button),
    .safety_output_pair_a_out(pair), .non_safe_message_output_out(msg),
    .aux_output_one_out(aux), .config_io_one_out(cio), .resolution_mm_out(res_mm),
    .vehicle_speed_out(speed), .response_time_out(resp_t), .irq_out(irq));

  reset_operator u_op (.clk_in(clk), .button_out(button));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // a nonzero stall holds bready or rready low that many edges, so the answer must stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    if (stall > 0) bready <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n == stall) bready <= 1'b1;
    end while (!(bvalid === 1'b1 && bready) && n < 100);
    chk(bvalid, 1'b1);
    br = bresp;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    if (stall > 0) rready <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n == stall) rready <= 1'b1;
    end while (!(rvalid === 1'b1 && rready) && n < 100);
    chk(rdata, e);
    chk(rresp, er);
  endtask : rchk

  // the fixed pin-to-output latency is 3 edges; 6 leaves margin
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  initial begin
    #3_000_000;
    failures++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(pair, 2'b00);
    chk(irq, 1'b0);
    foreach (rows[i]) rchk(rows[i].addr, rows[i].data, rows[i].resp);
    for (int k = 0; k < 6; k++) begin
      wr(`ADDR_CFG, 32'h5A00 | k);
      repeat (2) @(posedge clk);
      chk(res_mm, mm[k]);
    end
    wr(`ADDR_CFG, 32'h5A06);
    repeat (2) @(posedge clk);
    chk(res_mm, 8'h96);
    chk(speed, 8'h5A);
    stall = 4;
    wr(`ADDR_RESP, 32'h1234);
    rchk(`ADDR_RESP, 32'h1234, `RESP_OKAY);
    stall = 0;
    repeat (2) @(posedge clk);
    chk(resp_t, 16'h1234);
    wstrb <= 4'h2;
    wr(`ADDR_CFG, 32'h0000_3307);
    wstrb <= 4'hF;
    chk(speed, 8'h33);
    chk(res_mm, 8'h96);
    wr(8'h1C, 32'h1);
    chk(br, `RESP_SLVERR);
    wr(`ADDR_IRQ_MASK, 32'h7);
    u_op.press(5);
    settle();
    chk(pair, 2'b00);
    chk(irq, 1'b1);
    rchk(`ADDR_IRQ_STAT, 32'h4, `RESP_OKAY);
    @(posedge clk);
    chk(irq, 1'b0);
    wr(`ADDR_IRQ_MASK, 32'h0);
    u_op.press(50);
    settle();
    chk(pair, 2'b00);
    chk(irq, 1'b0);
    rchk(`ADDR_IRQ_STAT, 32'h4, `RESP_OKAY);
    wr(`ADDR_IRQ_MASK, 32'h7);
    u_op.press(20);
    settle();
    chk(pair, 2'b11);
    rchk(`ADDR_IRQ_STAT, 32'h2, `RESP_OKAY);
    prot_a[0] <= 1'b1;
    repeat (4) @(posedge clk);
    chk(pair, 2'b00);
    u_op.press(20);
    prot_a[0] <= 1'b0;
    settle();
    chk(pair, 2'b00);
    rchk(`ADDR_IRQ_STAT, 32'h5, `RESP_OKAY);
    u_op.press(20);
    settle();
    chk(pair, 2'b11);
    wr(`ADDR_CTRL, 32'h02);
    supply <= 1'b0;
    settle();
    supply <= 1'b1;
    settle();
    chk(pair, 2'b00);
    u_op.press(20);
    settle();
    chk(pair, 2'b11);
    prot_a[0] <= 1'b1;
    settle();
    chk(pair, 2'b00);
    prot_a[0] <= 1'b0;
    settle();
    chk(pair, 2'b11);
    wr(`ADDR_CTRL, 32'h06);
    prot_a[0] <= 1'b1;
    settle();
    prot_a[0] <= 1'b0;
    settle();
    chk(pair, 2'b00);
    u_op.press(20);
    settle();
    chk(pair, 2'b11);
    wr(`ADDR_CTRL, 32'h00);
    supply <= 1'b0;
    settle();
    chk(pair, 2'b00);
    supply <= 1'b1;
    settle();
    chk(pair, 2'b11);
    prot_a[0] <= 1'b1;
    settle();
    prot_a[0] <= 1'b0;
    settle();
    chk(pair, 2'b11);
    wr(`ADDR_CTRL, 32'h19);
    prot_b[3] <= 1'b1;
    settle();
    chk(pair, 2'b11);
    chk(msg, 1'b0);
    warn_a[3] <= 1'b1;
    warn_b[2] <= 1'b1;
    settle();
    chk(aux, 1'b1);
    chk(cio, 1'b0);
    warn_b[3] <= 1'b1;
    prot_a[2] <= 1'b1;
    settle();
    chk(cio, 1'b1);
    chk(pair, 2'b11);
    wr(`ADDR_ROUTE, 32'h1E);
    settle();
    chk(msg, 1'b1);
    chk(aux, 1'b1);
    chk(cio, 1'b0);
    wr(`ADDR_CTRL, 32'h18);
    settle();
    chk(cio, 1'b1);
    chk(aux, 1'b0);
    // mid-run reset must drop a running pair and relock
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(pair, 2'b00);
    chk(irq, 1'b0);
    rchk(`ADDR_CTRL, 32'h04, `RESP_OKAY);
    conclude();
  end
endmodule : tb_top

`default_nettype wire
